// File: design/dpcs_pkg.sv
// Constants and types for the drive-profile control/status interpreter
package dpcs_pkg;
  // ----------------------------------------------------------------
  // Field positions
  // ----------------------------------------------------------------
  localparam int CMD_RUN = 0;
  localparam int CMD_COAST_REL = 1;
  localparam int CMD_QUICK_REL = 2;
  localparam int CMD_OP_EN = 3;
  localparam int CMD_RAMP_EN = 4;
  localparam int CMD_RAMP_UNFRZ = 5;
  localparam int CMD_SETPT_EN = 6;
  localparam int CMD_FAULT_CLR = 7;
  localparam int CMD_PCD_EN = 10;
  localparam int CMD_REVERSE = 11;
  localparam int ST_SW_ON_RDY = 0;
  localparam int ST_RUN_RDY = 1;
  localparam int ST_RUNNING = 2;
  localparam int ST_TRIP = 3;
  localparam int ST_COAST_REL = 4;
  localparam int ST_QUICK_REL = 5;
  localparam int ST_SW_ON_INH = 6;
  localparam int ST_SPD_REACHED = 8;
  localparam int ST_REMOTE = 9;
  localparam int ST_SPD_LEVEL = 10;
  // ----------------------------------------------------------------
  // Reset values and scaling
  // ----------------------------------------------------------------
  localparam logic [15:0] CMD_RESET = 16'h0000;
  localparam logic [15:0] SPEED_RESET = 16'h0000;
  localparam logic [15:0] SPEED_FULL_SCALE = 16'h4000;
  localparam logic [1:0] LINK_MODE_LOCAL = 2'h0;

  typedef enum logic [4:0] {
    DPCS_NOT_READY = 5'b00001,
    DPCS_SW_ON_READY = 5'b00010,
    DPCS_RUN_READY = 5'b00100,
    DPCS_RUNNING = 5'b01000,
    DPCS_SWITCHING_OFF = 5'b10000
  } dpcs_state_t;
endpackage

// File: design/dpcs_core.sv
// Drive-profile command interpreter and status word builder
`timescale 1ns/1ps
module dpcs_core
  import dpcs_pkg::*;
#(
  parameter int SPEED_W = 16
) (
  // Clock and reset
  input wire logic CLK_SYS,
  input wire logic RESET_N,
  // Cyclic fieldbus words
  input wire logic [15:0] DRIVE_COMMAND_WORD,
  input wire logic DRIVE_COMMAND_VALID,
  input wire logic [SPEED_W-1:0] SPEED_REFERENCE_WORD,
  output logic [15:0] DRIVE_STATE_WORD,
  output logic [SPEED_W-1:0] SPEED_FEEDBACK_WORD,
  // Inverter settings
  input wire logic [1:0] LINK_MODE_SETTING,
  input wire logic [1:0] LOCAL_RUN_SETTING,
  input wire logic [SPEED_W-1:0] LOCAL_SPEED_SETTING,
  input wire logic [SPEED_W-1:0] SPEED_DETECT_THRESHOLD,
  input wire logic [15:0] QUICK_DECEL_TIME_SETTING,
  // Inverter status
  input wire logic TRIP_PRESENT,
  input wire logic MOTOR_STOPPED,
  input wire logic [SPEED_W-1:0] DETECTED_SPEED,
  // Commands to the inverter core
  output logic DRIVE_RUN,
  output logic DRIVE_REVERSE,
  output logic COAST_STOP,
  output logic QUICK_STOP,
  output logic [15:0] QUICK_DECEL_TIME,
  output logic RAMP_FREEZE,
  output logic FAULT_CLEAR,
  output logic [SPEED_W-1:0] SPEED_COMMAND
);

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  typedef struct packed {
    dpcs_state_t state;
    logic [15:0] cmd;
    logic [SPEED_W-1:0] ref_spd;
    logic local_block;
    logic [15:0] status;
    logic [SPEED_W-1:0] feedback;
    logic run;
    logic reverse;
    logic coast;
    logic quick;
    logic freeze;
    logic fclr;
    logic [SPEED_W-1:0] spd_cmd;
  } dpcs_regs_t;

  dpcs_regs_t r;
  dpcs_regs_t next_r;

  // Magnitude of a signed speed word
  function automatic logic [SPEED_W-1:0] spd_abs(input logic [SPEED_W-1:0] v);
    spd_abs = v[SPEED_W-1] ? SPEED_W'(-v) : v;
  endfunction

  logic gates_ok;
  logic releases;
  logic drive_en;

  // ----------------------------------------------------------------
  // Next-state logic
  // ----------------------------------------------------------------
  always_comb begin
    next_r = r;
    // Latch cyclic words only when accepted by the enable bit
    if (DRIVE_COMMAND_VALID && DRIVE_COMMAND_WORD[CMD_PCD_EN]) begin
      next_r.cmd = DRIVE_COMMAND_WORD;
      next_r.ref_spd = SPEED_REFERENCE_WORD;
    end
    releases = r.cmd[CMD_COAST_REL] && r.cmd[CMD_QUICK_REL];
    gates_ok = r.cmd[CMD_RAMP_EN] && r.cmd[CMD_RAMP_UNFRZ] && r.cmd[CMD_SETPT_EN] && r.cmd[CMD_PCD_EN];
    next_r.fclr = r.cmd[CMD_FAULT_CLR] && TRIP_PRESENT;
    // Profile sequencing
    unique case (r.state)
      DPCS_NOT_READY: begin
        if (releases && !r.cmd[CMD_RUN] && !TRIP_PRESENT) begin
          next_r.state = DPCS_SW_ON_READY;
        end
        if (r.cmd[CMD_COAST_REL] || r.cmd[CMD_QUICK_REL]) begin
          next_r.local_block = 1'b0;
        end
      end
      DPCS_SW_ON_READY: begin
        if (!releases || TRIP_PRESENT) begin
          next_r.state = DPCS_NOT_READY;
        end else if (r.cmd[CMD_RUN]) begin
          next_r.state = DPCS_RUN_READY;
        end
      end
      DPCS_RUN_READY: begin
        if (!releases || TRIP_PRESENT) begin
          next_r.state = DPCS_NOT_READY;
        end else if (!r.cmd[CMD_RUN]) begin
          next_r.state = DPCS_SW_ON_READY;
        end else if (r.cmd[CMD_OP_EN]) begin
          next_r.state = DPCS_RUNNING;
        end
      end
      DPCS_RUNNING: begin
        if (!releases || TRIP_PRESENT) begin
          next_r.state = DPCS_NOT_READY;
          next_r.local_block = !releases;
        end else if (!r.cmd[CMD_RUN]) begin
          next_r.state = DPCS_SWITCHING_OFF;
        end else if (!r.cmd[CMD_OP_EN]) begin
          next_r.state = DPCS_RUN_READY;
        end
      end
      DPCS_SWITCHING_OFF: begin
        if (!releases || TRIP_PRESENT) begin
          next_r.state = DPCS_NOT_READY;
          next_r.local_block = !releases;
        end else if (r.cmd[CMD_RUN]) begin
          next_r.state = DPCS_RUNNING;
        end else if (MOTOR_STOPPED) begin
          next_r.state = DPCS_SW_ON_READY;
        end
      end
      default: begin
        next_r.state = DPCS_NOT_READY;
      end
    endcase
    // A trip clear always lands in not ready
    if (r.fclr) begin
      next_r.state = DPCS_NOT_READY;
    end
    // Command outputs
    drive_en = (r.state == DPCS_RUNNING) && gates_ok && r.cmd[CMD_RUN];
    if (r.state == DPCS_NOT_READY) begin
      next_r.run = LOCAL_RUN_SETTING[0] || LOCAL_RUN_SETTING[1];
      next_r.reverse = LOCAL_RUN_SETTING[1] && !LOCAL_RUN_SETTING[0];
      next_r.spd_cmd = r.local_block ? SPEED_RESET : LOCAL_SPEED_SETTING;
      next_r.freeze = 1'b0;
    end else begin
      next_r.run = drive_en;
      next_r.reverse = r.cmd[CMD_REVERSE];
      next_r.spd_cmd = r.cmd[CMD_RAMP_EN] ? r.ref_spd : SPEED_RESET;
      next_r.freeze = !r.cmd[CMD_RAMP_UNFRZ];
    end
    next_r.coast = !r.cmd[CMD_COAST_REL];
    next_r.quick = !r.cmd[CMD_QUICK_REL];
    next_r.feedback = DETECTED_SPEED;
    // Status word, unused bits zero
    next_r.status = 16'h0000;
    next_r.status[ST_SW_ON_RDY] = (r.state == DPCS_SW_ON_READY);
    next_r.status[ST_RUN_RDY] = (r.state == DPCS_RUN_READY);
    next_r.status[ST_RUNNING] = (r.state == DPCS_RUNNING);
    next_r.status[ST_TRIP] = TRIP_PRESENT;
    next_r.status[ST_COAST_REL] = r.cmd[CMD_COAST_REL];
    next_r.status[ST_QUICK_REL] = r.cmd[CMD_QUICK_REL];
    next_r.status[ST_SW_ON_INH] = (r.state != DPCS_SW_ON_READY);
    next_r.status[ST_SPD_REACHED] = (DETECTED_SPEED == r.spd_cmd);
    next_r.status[ST_REMOTE] = (LINK_MODE_SETTING != LINK_MODE_LOCAL);
    next_r.status[ST_SPD_LEVEL] = spd_abs(DETECTED_SPEED) >= SPEED_DETECT_THRESHOLD;
  end

  // ----------------------------------------------------------------
  // Registers
  // ----------------------------------------------------------------
  always_ff @(posedge CLK_SYS or negedge RESET_N) begin
    if (!RESET_N) begin
      r <= '0;
      r.state <= DPCS_NOT_READY;
      r.cmd <= CMD_RESET;
      r.status <= 16'h0040;
    end else begin
      r <= next_r;
    end
  end

  // Outputs
  assign DRIVE_STATE_WORD = r.status;
  assign SPEED_FEEDBACK_WORD = r.feedback;
  assign DRIVE_RUN = r.run;
  assign DRIVE_REVERSE = r.reverse;
  assign COAST_STOP = r.coast;
  assign QUICK_STOP = r.quick;
  assign QUICK_DECEL_TIME = QUICK_DECEL_TIME_SETTING;
  assign RAMP_FREEZE = r.freeze;
  assign FAULT_CLEAR = r.fclr;
  assign SPEED_COMMAND = r.spd_cmd;

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  property p_inhibit_inverse;
    @(posedge CLK_SYS) disable iff (!RESET_N) r.status[ST_SW_ON_INH] == !r.status[ST_SW_ON_RDY];
  endproperty
  a_inhibit_inverse: assert property (p_inhibit_inverse) else $error("inhibit not inverse of ready");

  property p_run_gated;
    @(posedge CLK_SYS) disable iff (!RESET_N)
      ($past(r.state) != DPCS_NOT_READY) && DRIVE_RUN |-> $past(r.state == DPCS_RUNNING) && $past(gates_ok);
  endproperty
  a_run_gated: assert property (p_run_gated) else $error("run without running state and gates");

  property p_seq_ready;
    @(posedge CLK_SYS) disable iff (!RESET_N)
      (r.state == DPCS_NOT_READY) && $past(r.state) != DPCS_NOT_READY |=> r.state != DPCS_RUN_READY;
  endproperty
  a_seq_ready: assert property (p_seq_ready) else $error("skipped switch-on ready");

  property p_run_from_ready;
    @(posedge CLK_SYS) disable iff (!RESET_N)
      $rose(r.state == DPCS_RUNNING) |-> $past(r.state) inside {DPCS_RUN_READY, DPCS_SWITCHING_OFF};
  endproperty
  a_run_from_ready: assert property (p_run_from_ready) else $error("running entered out of order");

  property p_off_on_run_drop;
    @(posedge CLK_SYS) disable iff (!RESET_N)
      (r.state == DPCS_RUNNING) && releases && !TRIP_PRESENT && !r.cmd[CMD_RUN] && !r.fclr
      |=> r.state == DPCS_SWITCHING_OFF;
  endproperty
  a_off_on_run_drop: assert property (p_off_on_run_drop) else $error("no switching off on run drop");

  property p_echo;
    @(posedge CLK_SYS) disable iff (!RESET_N)
      1'b1 |=> DRIVE_STATE_WORD[ST_COAST_REL] == $past(r.cmd[CMD_COAST_REL])
               && DRIVE_STATE_WORD[ST_QUICK_REL] == $past(r.cmd[CMD_QUICK_REL]);
  endproperty
  a_echo: assert property (p_echo) else $error("release echo wrong");

  property p_remote;
    @(posedge CLK_SYS) disable iff (!RESET_N)
      1'b1 |=> DRIVE_STATE_WORD[ST_REMOTE] == ($past(LINK_MODE_SETTING) != 2'h0);
  endproperty
  a_remote: assert property (p_remote) else $error("remote bit wrong");

  property p_unused_zero;
    @(posedge CLK_SYS) disable iff (!RESET_N) DRIVE_STATE_WORD[15:11] == 5'h0 && !DRIVE_STATE_WORD[7];
  endproperty
  a_unused_zero: assert property (p_unused_zero) else $error("unused status bits set");

  property p_cmd_gate;
    @(posedge CLK_SYS) disable iff (!RESET_N)
      DRIVE_COMMAND_VALID && !DRIVE_COMMAND_WORD[CMD_PCD_EN] |=> r.cmd == $past(r.cmd);
  endproperty
  a_cmd_gate: assert property (p_cmd_gate) else $error("disabled command word taken");
endmodule

// File: test/dpcs_master_model.sv
// Fieldbus master model that sends the cyclic command and speed words
`timescale 1ns/1ps
module dpcs_master_model (
  // Clock
  input wire logic CLK_SYS,
  // Cyclic words toward the card
  output logic [15:0] DRIVE_COMMAND_WORD,
  output logic DRIVE_COMMAND_VALID,
  output logic [15:0] SPEED_REFERENCE_WORD
);
  // ----------------------------------------------------------------
  // Frame driver
  // ----------------------------------------------------------------
  // Idle words until the first frame
  initial begin
    DRIVE_COMMAND_WORD = 16'h0000;
    DRIVE_COMMAND_VALID = 1'b0;
    SPEED_REFERENCE_WORD = 16'h0000;
  end
  // One frame after a falling edge, held until the next frame
  task automatic send(input logic [15:0] cmd, input logic [15:0] spd);
    @(negedge CLK_SYS);
    DRIVE_COMMAND_WORD = cmd;
    SPEED_REFERENCE_WORD = spd;
    DRIVE_COMMAND_VALID = 1'b1;
  endtask
endmodule

// File: test/tb_dpcs_core.sv
// Self-checking bench for the drive-profile interpreter
`timescale 1ns/1ps
module tb_dpcs_core;
  import dpcs_pkg::*;
  typedef struct packed {
    logic [15:0] cmd;
    logic [15:0] mask;
    logic [15:0] sw;
    logic run;
    logic rev;
  } dpcs_row_t;
  // ----------------------------------------------------------------
  // Signals and rows: command, status mask, status, run, reverse
  // ----------------------------------------------------------------
  localparam dpcs_row_t ROWS [0:7] = '{
    '{16'h0406, 16'hFEFF, 16'h0231, 1'b0, 1'b0},
    '{16'h0477, 16'hFEBC, 16'h0230, 1'b0, 1'b0},
    '{16'h047F, 16'hFEBC, 16'h0234, 1'b1, 1'b0},
    '{16'h043F, 16'hFEB8, 16'h0230, 1'b0, 1'b0},
    '{16'h0C7F, 16'hFEBC, 16'h0234, 1'b1, 1'b1},
    '{16'h007E, 16'hFEBC, 16'h0234, 1'b1, 1'b1},
    '{16'h0476, 16'hFEFF, 16'h0231, 1'b0, 1'b0},
    '{16'h0400, 16'hFEFF, 16'h0240, 1'b0, 1'b0}};
  logic clk_sys, reset_n, trip_present;
  logic [1:0] link_mode;
  logic [15:0] cmd_word, spd_ref, state_word, fb_word, det_speed, spd_cmd, qd_time;
  logic cmd_valid, run, rev, coast, quick, freeze, fclr;
  int fail_count, comparisons, cycles;
  // Clock
  initial begin
    clk_sys = 1'b0;
    forever #10 clk_sys = ~clk_sys;
  end
  dpcs_master_model u_dpcs_master_model (.CLK_SYS(clk_sys), .DRIVE_COMMAND_WORD(cmd_word),
    .DRIVE_COMMAND_VALID(cmd_valid), .SPEED_REFERENCE_WORD(spd_ref));
  dpcs_core u_dpcs_core (.CLK_SYS(clk_sys), .RESET_N(reset_n), .DRIVE_COMMAND_WORD(cmd_word),
    .DRIVE_COMMAND_VALID(cmd_valid), .SPEED_REFERENCE_WORD(spd_ref), .DRIVE_STATE_WORD(state_word),
    .SPEED_FEEDBACK_WORD(fb_word), .LINK_MODE_SETTING(link_mode), .LOCAL_RUN_SETTING(2'h0),
    .LOCAL_SPEED_SETTING(16'h0100), .SPEED_DETECT_THRESHOLD(16'h0100),
    .QUICK_DECEL_TIME_SETTING(16'h1234), .TRIP_PRESENT(trip_present), .MOTOR_STOPPED(1'b1),
    .DETECTED_SPEED(det_speed), .DRIVE_RUN(run), .DRIVE_REVERSE(rev), .COAST_STOP(coast),
    .QUICK_STOP(quick), .QUICK_DECEL_TIME(qd_time), .RAMP_FREEZE(freeze), .FAULT_CLEAR(fclr),
    .SPEED_COMMAND(spd_cmd));
  // ----------------------------------------------------------------
  // Checking and closing
  // ----------------------------------------------------------------
  task automatic chk(input logic [15:0] got, input logic [15:0] exp, input string what);
    comparisons++;
    if (got !== exp) begin
      fail_count++;
      $display("[ERR] %0t %s got %h expected %h", $time, what, got, exp);
    end
  endtask
  task automatic end_of_test();
    $display("comparisons %0d mismatches %0d", comparisons, fail_count);
    if (fail_count == 0 && comparisons > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask
  // Status settles one edge after a state change, which may itself chain once
  task automatic settle();
    repeat (4) @(posedge clk_sys);
    @(negedge clk_sys);
  endtask
  // Cycle ceiling against a hang
  always @(posedge clk_sys) begin
    cycles++;
    if (cycles == 3000) begin
      fail_count++;
      $display("[ERR] %0t cycle limit reached", $time);
      end_of_test();
    end
  end
  // ----------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------
  initial begin
    reset_n = 1'b0;
    trip_present = 1'b0;
    link_mode = 2'h1;
    det_speed = 16'h0000;
    repeat (16) @(negedge clk_sys);
    chk(state_word, 16'h0040, "reset status");
    reset_n = 1'b1;
    settle();
    chk(qd_time, 16'h1234, "quick decel time");
    $display("test reset done");
    // Profile walk through the row table
    foreach (ROWS[i]) begin
      u_dpcs_master_model.send(ROWS[i].cmd, 16'h2000);
      settle();
      chk(state_word & ROWS[i].mask, ROWS[i].sw, "status word");
      chk({15'h0, state_word[6]}, {15'h0, ~state_word[0]}, "inhibit bit");
      chk({14'h0, run, rev}, {14'h0, ROWS[i].run, ROWS[i].rev}, "run and direction");
    end
    $display("test profile table done");
    // Run bit straight from not ready must not start the motor
    u_dpcs_master_model.send(16'h047F, 16'h2000);
    settle();
    chk(state_word & 16'hFEFF, 16'h0270, "no skip status");
    chk({15'h0, run}, 16'h0000, "no skip run");
    chk(spd_cmd, 16'h0100, "local speed in not ready");
    chk({15'h0, freeze}, 16'h0000, "no freeze in not ready");
    u_dpcs_master_model.send(16'h0400, 16'h2000);
    settle();
    chk({14'h0, coast, quick}, 16'h0003, "stop commands");
    det_speed = 16'h0100;
    settle();
    chk({15'h0, state_word[8]}, 16'h0001, "speed reached");
    $display("test run without sequence done");
    // Link mode and speed level bits
    det_speed = 16'h0200;
    for (int m = 0; m < 4; m++) begin
      link_mode = m[1:0];
      settle();
      chk({14'h0, state_word[10:9]}, {14'h0, 1'b1, m != 0}, "link and level bits");
      chk(fb_word, 16'h0200, "speed feedback");
    end
    $display("test link mode done");
    // Trip report and fault clear
    trip_present = 1'b1;
    settle();
    chk({15'h0, state_word[3]}, 16'h0001, "trip bit");
    u_dpcs_master_model.send(16'h0486, 16'h0000);
    for (int k = 0; k < 6 && fclr !== 1'b1; k++) begin
      @(negedge clk_sys);
    end
    chk({15'h0, fclr}, 16'h0001, "fault clear pulse");
    settle();
    chk({13'h0, state_word[2:0]}, 16'h0000, "not ready after clear");
    trip_present = 1'b0;
    settle();
    chk({15'h0, fclr}, 16'h0000, "fault clear drops with trip");
    $display("test fault clear done");
    end_of_test();
  end
endmodule
